// ---- design/cpa_charger_protection_alerts.sv ----
// supervision of battery, output and temperature faults with alert pulse
// assumes analog comparator levels arrive asynchronously,
// temperature codes and host controls come from sys_clk logic
// Function
// - battery over-voltage fault stops conversion, clears enable, sets bits, alerts unless suppressed.
// - battery over-voltage alarm only alerts, conversion keeps running.
// - off bits disable battery over-voltage fault and alarm detection.
// - battery over-current fault acts after deglitch, clears enable, sets bits, alerts.
// - battery over-current alarm alerts without stopping conversion.
// - off bits disable battery over-current fault and alarm detection.
// - enabled output over-voltage stops conversion, clears enable, sets bits, alerts.
// - output over-voltage off bit makes the condition ignored.
// - connector and battery temperature faults trip when sensed voltage falls below threshold.
// - temperature faults stop conversion, clear enable, set matching bits.
// - each temperature fault has its own off bit.
// - combined temperature alarm fires within five percent of a fault threshold.
// - disabled temperature fault input never fires combined alarm.
// - die alarm sets bits and alerts while switching continues.
// - alert output idles high and pulses low for fixed time.
// - live bits follow present condition state.
// - latched bits record events and clear on host read.
// - persisting event after read does not alert again.
// - suppress blocks only the alert; bits still update.
// - strap sampled after power-on selects role and default address.
// - shared pins are sync out or sense in, or temperature in and sync in.
// - switching frequency limited to 500 kHz in primary role; secondary role follows sync in without a limit.
// - sampled role readable as two-bit field.
// - disabled detection holds its live and latched bits in reset, no alert.
// - suppress does not disable protective shutdown.
`timescale 1ns/1ps
`default_nettype none
`include "cpa_defines.svh"
module cpa_charger_protection_alerts
  import cpa_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // analog comparator levels
  input wire logic bat_ov_fault_cmp,
  input wire logic bat_ov_alarm_cmp,
  input wire logic bat_oc_fault_cmp,
  input wire logic bat_oc_alarm_cmp,
  input wire logic out_ov_cmp,
  // temperature codes and thresholds
  input wire logic [7:0] connector_temp_code,
  input wire logic [7:0] connector_temp_thr,
  input wire logic [7:0] battery_temp_code,
  input wire logic [7:0] battery_temp_thr,
  input wire logic [7:0] die_temp_code,
  input wire logic [7:0] die_fault_thr,
  input wire logic [7:0] die_alarm_thr,
  // host controls
  input wire cpa_cond_t fault_off,
  input wire cpa_cond_t suppress,
  input wire logic event_read,
  input wire logic charge_en_set,
  input wire logic charge_en_clr,
  input wire logic [7:0] sw_half_period,
  // status
  output cpa_cond_t live,
  output cpa_cond_t latched,
  output logic charge_enable_bit,
  output logic converter_run,
  output logic [1:0] role_config_field,
  output logic [6:0] serial_address,
  // alert pin, open drain
  output logic alert_n_out,
  output logic alert_n_oe_n,
  // shared pins and strap
  input wire logic [2:0] role_address_strap,
  input wire logic sense_neg_or_sync_in_pin,
  output logic battemp_or_sync_out_pin,
  output logic battemp_or_sync_out_oe_n,
  output logic battemp_from_pin,
  output logic sw_phase
);
  logic [8:0] synced;
  logic oc_raw;
  logic [7:0] oc_dg_cnt;
  logic [9:0] qual;
  logic [9:0] new_evt;
  logic alert_pend;
  cpa_alert_st_t alert_st;
  logic [11:0] pulse_cnt;
  logic [2:0] settle_cnt;
  logic strap_done;
  logic [7:0] sw_cnt;
  logic [7:0] half_eff;
  logic sync_in_q;

  // margin five percent above a threshold
  function automatic logic [8:0] cpa_margin(input logic [7:0] thr);
    cpa_margin = {1'b0, thr} + {1'b0, thr / 8'd20};
  endfunction : cpa_margin
  // true when a code lies below a nine-bit limit
  function automatic logic cpa_below(input logic [7:0] code, input logic [8:0] lim);
    cpa_below = {1'b0, code} < lim;
  endfunction : cpa_below

  cpa_sync #(.W(9)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({role_address_strap, sense_neg_or_sync_in_pin, out_ov_cmp,
               bat_oc_alarm_cmp, bat_oc_fault_cmp, bat_ov_alarm_cmp, bat_ov_fault_cmp}),
    .sync_out(synced)
  );

  assign oc_raw = synced[2] & ~fault_off.battery_overcurrent_fault;
  assign sync_in_q = synced[5];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oc_dg_cnt <= 8'h00;
    end else if (!oc_raw) begin
      oc_dg_cnt <= 8'h00;
    end else if (oc_dg_cnt != 8'(`CPA_BATOC_DG_CYC)) begin
      oc_dg_cnt <= oc_dg_cnt + 8'h01;
    end
  end

  // qualified conditions, off bits force them low
  always_comb begin
    qual = 10'h000;
    qual[`CPA_B_BAT_OV_FLT] = synced[0];
    qual[`CPA_B_BAT_OV_ALM] = synced[1];
    qual[`CPA_B_BAT_OC_FLT] = oc_dg_cnt == 8'(`CPA_BATOC_DG_CYC);
    qual[`CPA_B_BAT_OC_ALM] = synced[3];
    qual[`CPA_B_OUT_OV_FLT] = synced[4];
    qual[`CPA_B_CONN_FLT] = connector_temp_code < connector_temp_thr;
    qual[`CPA_B_BATT_FLT] = battery_temp_code < battery_temp_thr && battemp_from_pin;
    qual[`CPA_B_DIE_FLT] = die_temp_code > die_fault_thr;
    // within five percent; disabled input excluded
    qual[`CPA_B_COMB_ALM] =
      (cpa_below(connector_temp_code, cpa_margin(connector_temp_thr)) && !fault_off.connector_temp_fault) ||
      (cpa_below(battery_temp_code, cpa_margin(battery_temp_thr)) && !fault_off.battery_temp_fault &&
       battemp_from_pin);
    qual[`CPA_B_DIE_ALM] = die_temp_code > die_alarm_thr;
    qual = qual & ~fault_off;
  end

  // event is the rise of a qualified condition
  assign new_evt = qual & ~live;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      live <= '0;
    end else begin
      live <= qual;
    end
  end

  // latched bits, set wins over read clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      latched <= '0;
    end else begin
      latched <= ((event_read ? 10'h000 : latched) | new_evt) & ~fault_off;
    end
  end

  // request only on a fresh unsuppressed event
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alert_pend <= 1'b0;
    end else if (|(new_evt & ~suppress)) begin
      alert_pend <= 1'b1;
    end else if (alert_st == CPA_AL_IDLE) begin
      alert_pend <= 1'b0;
    end
  end

  // fixed-length low pulse on the alert pin
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alert_st <= CPA_AL_IDLE;
      pulse_cnt <= 12'h000;
      alert_n_oe_n <= 1'b1;
      alert_n_out <= 1'b0;
    end else begin
      alert_n_out <= 1'b0;
      case (alert_st)
        CPA_AL_IDLE: begin
          if (alert_pend) begin
            alert_st <= CPA_AL_PULSE;
            pulse_cnt <= 12'h000;
            alert_n_oe_n <= 1'b0;
          end
        end
        CPA_AL_PULSE: begin
          if (pulse_cnt == 12'(`CPA_ALERT_CYC - 1)) begin
            alert_st <= CPA_AL_GAP;
            alert_n_oe_n <= 1'b1;
          end else begin
            pulse_cnt <= pulse_cnt + 12'h001;
          end
        end
        CPA_AL_GAP: begin
          alert_st <= CPA_AL_IDLE;
        end
        default: begin
          alert_st <= CPA_AL_IDLE;
          alert_n_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // any fault clears enable, only host sets it again
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      charge_enable_bit <= 1'b0;
      converter_run <= 1'b0;
    end else begin
      if (|(qual & `CPA_FAULT_MASK)) begin
        charge_enable_bit <= 1'b0;
      end else if (charge_en_clr) begin
        charge_enable_bit <= 1'b0;
      end else if (charge_en_set) begin
        charge_enable_bit <= 1'b1;
      end
      converter_run <= charge_enable_bit && !(|(qual & `CPA_FAULT_MASK));
    end
  end

  // strap caught once the synchroniser settles
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      settle_cnt <= 3'h0;
      strap_done <= 1'b0;
      role_config_field <= CPA_ROLE_STANDALONE;
      serial_address <= `CPA_ADDR_BASE;
    end else if (!strap_done) begin
      if (settle_cnt == `CPA_STRAP_SETTLE) begin
        strap_done <= 1'b1;
        role_config_field <= (synced[7:6] == 2'h3) ? CPA_ROLE_STANDALONE : synced[7:6];
        serial_address <= `CPA_ADDR_BASE | {6'h00, synced[8]};
      end else begin
        settle_cnt <= settle_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      battemp_from_pin <= 1'b1;
      battemp_or_sync_out_oe_n <= 1'b1;
      battemp_or_sync_out_pin <= 1'b0;
    end else begin
      battemp_from_pin <= role_config_field != CPA_ROLE_PRIMARY;
      battemp_or_sync_out_oe_n <= role_config_field != CPA_ROLE_PRIMARY;
      battemp_or_sync_out_pin <= sw_phase;
    end
  end

  // half period clamped in primary or secondary role
  always_comb begin
    half_eff = (sw_half_period == 8'h00) ? 8'h01 : sw_half_period;
    if (role_config_field != CPA_ROLE_STANDALONE && half_eff < 8'(`CPA_SW_MIN_HALF)) begin
      half_eff = 8'(`CPA_SW_MIN_HALF);
    end
  end

  // own phase counter, or follow the primary in secondary role
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sw_cnt <= 8'h00;
      sw_phase <= 1'b0;
    end else if (!converter_run) begin
      sw_cnt <= 8'h00;
      sw_phase <= 1'b0;
    end else if (role_config_field == CPA_ROLE_SECONDARY) begin
      sw_phase <= sync_in_q;
    end else if (sw_cnt >= half_eff - 8'h01) begin
      sw_cnt <= 8'h00;
      sw_phase <= ~sw_phase;
    end else begin
      sw_cnt <= sw_cnt + 8'h01;
    end
  end

  sequence s_new_unsup;
    (|(new_evt & ~suppress)) && alert_st == CPA_AL_IDLE && !alert_pend;
  endsequence
  sequence s_pulse_low;
    ##[1:3] !alert_n_oe_n;
  endsequence
  bat_ov_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
    live.battery_overvoltage_fault |-> !charge_enable_bit && !converter_run)
    else $error("battery over-voltage fault left charging enabled");
  alarm_keeps_run_a: assert property (@(posedge sys_clk) disable iff (rst)
    live.battery_overvoltage_alarm && !(|(live & `CPA_FAULT_MASK)) && $past(charge_enable_bit) &&
    !$past(charge_en_clr) && !(|($past(qual) & `CPA_FAULT_MASK)) |-> charge_enable_bit)
    else $error("alarm alone stopped charging");
  off_holds_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
    ((live | latched) & $past(fault_off)) == 10'h000)
    else $error("disabled condition shows status");
  oc_deglitch_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(live.battery_overcurrent_fault) |-> $past(oc_dg_cnt) == 8'(`CPA_BATOC_DG_CYC) && $past(synced[2], 2))
    else $error("over-current fault before deglitch");
  hot_falling_a: assert property (@(posedge sys_clk) disable iff (rst)
    connector_temp_code < connector_temp_thr && !fault_off.connector_temp_fault |=> live.connector_temp_fault)
    else $error("connector hot not detected");
  read_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    event_read |=> latched == ($past(new_evt) & ~$past(fault_off)))
    else $error("latched bits not cleared by read");
  alert_issue_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_new_unsup |-> s_pulse_low)
    else $error("fresh event without alert pulse");
  pulse_len_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(alert_n_oe_n) |-> $past(pulse_cnt) == 12'(`CPA_ALERT_CYC - 1) && alert_n_out == 1'b0)
    else $error("alert pulse length wrong");
  suppressed_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(alert_pend) |-> |($past(new_evt) & ~$past(suppress)))
    else $error("alert requested without unsuppressed event");
  strap_role_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(strap_done) |-> role_config_field == (($past(synced[7:6]) == 2'h3) ? 2'h0 : $past(synced[7:6])))
    else $error("role field does not match strap");
  sw_limit_a: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(sw_phase) && converter_run && role_config_field == CPA_ROLE_PRIMARY |->
    $past(sw_cnt) >= 8'(`CPA_SW_MIN_HALF - 1))
    else $error("switching faster than the role limit");
endmodule : cpa_charger_protection_alerts
`default_nettype wire

// ---- design/cpa_defines.svh ----
// constants for the charger protection and alert block
// assumes a 20 MHz sys_clk; included by bare name
`ifndef CPA_DEFINES_SVH
`define CPA_DEFINES_SVH

`define CPA_CLK_KHZ 20000
// deglitch before the battery over-current fault acts
`define CPA_BATOC_DG_NS 1000
`define CPA_BATOC_DG_CYC ((`CPA_BATOC_DG_NS * `CPA_CLK_KHZ + 999999) / 1000000)
// length of the alert low pulse
`define CPA_ALERT_NS 100000
`define CPA_ALERT_CYC ((`CPA_ALERT_NS * `CPA_CLK_KHZ) / 1000000)
// switching limit in primary role
`define CPA_SW_MAX_KHZ 500
`define CPA_SW_MIN_HALF ((`CPA_CLK_KHZ + 2 * `CPA_SW_MAX_KHZ - 1) / (2 * `CPA_SW_MAX_KHZ))
// strap sampling waits for the synchroniser to settle
`define CPA_STRAP_SETTLE 3'h4
// serial address base, low bit taken from the strap
`define CPA_ADDR_BASE 7'h64
// condition vector positions
`define CPA_B_BAT_OV_FLT 0
`define CPA_B_BAT_OV_ALM 1
`define CPA_B_BAT_OC_FLT 2
`define CPA_B_BAT_OC_ALM 3
`define CPA_B_OUT_OV_FLT 4
`define CPA_B_CONN_FLT 5
`define CPA_B_BATT_FLT 6
`define CPA_B_DIE_FLT 7
`define CPA_B_COMB_ALM 8
`define CPA_B_DIE_ALM 9
// conditions that stop conversion
`define CPA_FAULT_MASK 10'h0f5

`endif

// ---- design/cpa_pkg.sv ----
// types for the charger protection and alert block
// assumes cpa_defines.svh carries the numbers
package cpa_pkg;

  // one bit per monitored condition, lsb is battery over-voltage fault
  typedef struct packed {
    logic die_temp_alarm;
    logic combined_temp_alarm;
    logic die_temp_fault;
    logic battery_temp_fault;
    logic connector_temp_fault;
    logic output_overvoltage_fault;
    logic battery_overcurrent_alarm;
    logic battery_overcurrent_fault;
    logic battery_overvoltage_alarm;
    logic battery_overvoltage_fault;
  } cpa_cond_t;

  typedef enum logic [1:0] {
    CPA_ROLE_STANDALONE = 2'h0,
    CPA_ROLE_PRIMARY = 2'h1,
    CPA_ROLE_SECONDARY = 2'h2
  } cpa_role_t;

  typedef enum logic [1:0] {
    CPA_AL_IDLE = 2'h0,
    CPA_AL_PULSE = 2'h1,
    CPA_AL_GAP = 2'h3
  } cpa_alert_st_t;

endpackage : cpa_pkg

// ---- design/cpa_sync.sv ----
// three-stage input synchroniser with agreement filter
// assumes inputs are asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module cpa_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit moves only when stages two and three agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_out <= '0;
    end else begin
      sync_out <= (s2 & s3) | (sync_out & (s2 | s3));
    end
  end
endmodule : cpa_sync
`default_nettype wire

// ---- testbench/charger_protection_alerts_test.sv ----
// self-checking bench for the charger protection and alert block
// assumes the host model on the alert pin; inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module charger_protection_alerts_test
  import cpa_pkg::*;
;
  // conditions that stop conversion, and alert length at 20 MHz
  localparam logic [9:0] FAULTS = 10'h0f5;
  localparam int ALERT_CYC = 2000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic bat_ov_flt = 1'b0;
  logic bat_ov_alm = 1'b0;
  logic bat_oc_flt = 1'b0;
  logic bat_oc_alm = 1'b0;
  logic out_ov = 1'b0;
  logic [7:0] conn_code = 8'hc8;
  logic [7:0] bat_code = 8'hc8;
  logic [7:0] die_code = 8'h28;
  logic [9:0] off_v = 10'h000;
  logic [9:0] sup_v = 10'h000;
  logic event_read = 1'b0;
  logic en_set = 1'b0;
  logic en_clr = 1'b0;
  logic [7:0] half = 8'h02;
  logic [2:0] strap = 3'h0;
  logic sync_in = 1'b0;
  logic [9:0] live_v;
  logic [9:0] latched_v;
  logic charge_enable_bit;
  logic converter_run;
  logic [1:0] role_cfg;
  logic [6:0] addr;
  logic alert_n_out;
  logic alert_n_oe_n;
  logic sync_out;
  logic sync_oe_n;
  logic battemp_from_pin;
  logic sw_phase;
  int pulses;
  int width;
  int errors = 0;
  int samples_checked = 0;

  always #25 sys_clk = ~sys_clk;
  always #1250 sync_in = ~sync_in;

  cpa_charger_protection_alerts cpa_charger_protection_alerts_i (
    .sys_clk(sys_clk), .rst(rst),
    .bat_ov_fault_cmp(bat_ov_flt), .bat_ov_alarm_cmp(bat_ov_alm),
    .bat_oc_fault_cmp(bat_oc_flt), .bat_oc_alarm_cmp(bat_oc_alm), .out_ov_cmp(out_ov),
    .connector_temp_code(conn_code), .connector_temp_thr(8'h64),
    .battery_temp_code(bat_code), .battery_temp_thr(8'h64),
    .die_temp_code(die_code), .die_fault_thr(8'h8c), .die_alarm_thr(8'h78),
    .fault_off(off_v), .suppress(sup_v), .event_read(event_read),
    .charge_en_set(en_set), .charge_en_clr(en_clr), .sw_half_period(half),
    .live(live_v), .latched(latched_v), .charge_enable_bit(charge_enable_bit),
    .converter_run(converter_run), .role_config_field(role_cfg), .serial_address(addr),
    .alert_n_out(alert_n_out), .alert_n_oe_n(alert_n_oe_n),
    .role_address_strap(strap), .sense_neg_or_sync_in_pin(sync_in),
    .battemp_or_sync_out_pin(sync_out), .battemp_or_sync_out_oe_n(sync_oe_n),
    .battemp_from_pin(battemp_from_pin), .sw_phase(sw_phase)
  );

  cpa_host_model cpa_host_model_i (
    .sys_clk(sys_clk), .alert_n_out(alert_n_out), .alert_n_oe_n(alert_n_oe_n),
    .pulse_count(pulses), .last_width(width)
  );

  task tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  task automatic strobe(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : strobe

  task check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check

  task print_verdict;
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // temperature codes: thresholds 100 (hot below), die fault 140, die alarm 120
  task set_cond(input int i, input logic v);
    case (i)
      0: bat_ov_flt = v;
      1: bat_ov_alm = v;
      2: bat_oc_flt = v;
      3: bat_oc_alm = v;
      4: out_ov = v;
      5: conn_code = v ? 8'h50 : 8'hc8;
      6: bat_code = v ? 8'h50 : 8'hc8;
      7: die_code = v ? 8'h96 : 8'h28;
      8: conn_code = v ? 8'h66 : 8'hc8;
      default: die_code = v ? 8'h80 : 8'h28;
    endcase
  endtask : set_cond

  task do_reset(input logic [2:0] s);
    rst = 1'b1;
    strap = s;
    tick(6);
    rst = 1'b0;
    tick(8);
  endtask : do_reset

  task automatic half_len(output int n);
    logic p;
    int g;
    p = sw_phase;
    g = 0;
    while (sw_phase === p && g < 100) begin
      tick(1);
      g++;
    end
    p = sw_phase;
    n = 0;
    while (sw_phase === p && n < 100) begin
      tick(1);
      n++;
    end
  endtask : half_len

  // one condition raised, reported, read, persisting, then removed
  task automatic run_cond(input int i, input bit dis, input bit sup);
    int n;
    int p0;
    bit flt;
    bit ok;
    flt = FAULTS[i];
    ok = !dis && !sup;
    strobe(en_set);
    tick(2);
    check(charge_enable_bit, 1'b1, "enable set");
    off_v[i] = dis;
    if (dis && i == 7) off_v[9] = 1'b1;
    sup_v[i] = sup;
    p0 = pulses;
    tick(2);
    set_cond(i, 1'b1);
    n = 0;
    while (live_v[i] !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    check(live_v[i], !dis, "live");
    check(latched_v[i], !dis, "latched");
    check(charge_enable_bit, dis || !flt, "enable");
    check(converter_run, dis || !flt, "run");
    if (!dis) check(n > 20, i == 2, "deglitch");
    tick(2100);
    check(pulses - p0, ok, "alert count");
    if (ok) check(width, ALERT_CYC, "alert width");
    strobe(event_read);
    tick(2);
    check(latched_v[i], 1'b0, "read clear");
    tick(40);
    check(pulses - p0, ok, "repeat alert");
    set_cond(i, 1'b0);
    tick(10);
    check(live_v[i], 1'b0, "live fall");
    check(charge_enable_bit, dis || !flt, "stays stopped");
    strobe(event_read);
    tick(2);
    off_v = 10'h000;
    sup_v = 10'h000;
  endtask : run_cond

  logic [2:0] straps [3] = '{3'h0, 3'h5, 3'h2};
  cpa_role_t exp_role [3] = '{CPA_ROLE_STANDALONE, CPA_ROLE_PRIMARY, CPA_ROLE_SECONDARY};

  initial begin
    int n;
    for (int r = 0; r < 3; r++) begin
      do_reset(straps[r]);
      check(role_cfg, exp_role[r], "role");
      check(addr, (r == 1) ? 7'h65 : 7'h64, "address");
      check(sync_oe_n, r != 1, "sync out drive");
      check(battemp_from_pin, r != 1, "temp pin use");
      check(alert_n_oe_n, 1'b1, "alert idle");
      strobe(en_set);
      tick(2);
      check(converter_run, 1'b1, "run");
      half_len(n);
      check(n, (r == 1) ? 20 : ((r == 2) ? 25 : 2), "half period");
      check(sync_out, !sw_phase, "sync out pin");
      strobe(en_clr);
      tick(2);
      check(charge_enable_bit, 1'b0, "enable clear");
    end
    do_reset(3'h0);
    for (int i = 0; i < 10; i++) run_cond(i, 1'b0, 1'b0);
    for (int i = 0; i < 10; i++) run_cond(i, 1'b1, 1'b0);
    run_cond(0, 1'b0, 1'b1);
    run_cond(9, 1'b0, 1'b1);
    print_verdict();
  end

  // bound on the whole run, well above the expected 50000 cycles
  initial begin
    repeat (90000) @(posedge sys_clk);
    errors++;
    print_verdict();
  end
endmodule : charger_protection_alerts_test
`default_nettype wire

// ---- testbench/cpa_host_model.sv ----
// host side model: pull-up on the alert line, pulse counter and width
// assumes alert_n_oe_n low means the device pulls the line low
`timescale 1ns/1ps
`default_nettype none
module cpa_host_model (
  // clock
  input wire logic sys_clk,
  // alert pin
  input wire logic alert_n_out,
  input wire logic alert_n_oe_n,
  // observations
  output int pulse_count,
  output int last_width
);
  logic alert_wire;
  int run;
  assign alert_wire = alert_n_oe_n ? 1'b1 : alert_n_out;
  initial begin
    pulse_count = 0;
    last_width = 0;
    run = 0;
  end
  // low cycles counted, pulse booked on release
  always @(posedge sys_clk) begin
    if (alert_wire === 1'b0) begin
      run = run + 1;
    end else if (run != 0) begin
      pulse_count = pulse_count + 1;
      last_width = run;
      run = 0;
    end
  end
endmodule : cpa_host_model
`default_nettype wire
